// ==== shared/frw_pkg.sv ====
// Shared constants and types for the flash rewrite sequencer
package frw_pkg;

  // Rewrite mode encodings of rewrite_mode_select
  localparam logic REWRITE_MODE_RAM_RESIDENT   = 1'b0;
  localparam logic REWRITE_MODE_FLASH_RESIDENT = 1'b1;

  // Field positions in flash_control_register_a
  localparam int CTLA_RDY_BIT        = 0;
  localparam int CTLA_MODE_SEL_BIT   = 1;
  localparam int CTLA_CPU_REWRITE_BIT = 2;
  localparam int CTLA_WIDTH          = 8;

  // Field positions in flash_control_register_b
  localparam int CTLB_LOCK_DIS_BIT   = 0;
  localparam int CTLB_WIDTH          = 8;

  // Field positions in flash_status_register
  localparam int STAT_PROG_ERR_BIT   = 0;
  localparam int STAT_ERASE_ERR_BIT  = 1;
  localparam int STAT_ABORTED_BIT    = 2;
  localparam int STAT_WIDTH          = 8;

  // Reset values
  localparam logic [CTLA_WIDTH-1:0] CTLA_RESET = 8'h01;
  localparam logic [CTLB_WIDTH-1:0] CTLB_RESET = 8'h00;
  localparam logic [STAT_WIDTH-1:0] STAT_RESET = 8'h00;

  // Timing: base command time and growth per cycle of wear
  localparam int CLK_MHZ            = 125;
  localparam int BASE_CMD_TIME_US   = 20;
  localparam int BASE_CMD_CYCLES    = BASE_CMD_TIME_US * CLK_MHZ;
  localparam int WEAR_STEP_CYCLES   = 8;
  localparam int CNT_WIDTH          = 32;
  localparam int WEAR_WIDTH         = 16;

  // Software commands
  typedef enum logic [2:0]
  {
    FRW_CMD_NONE       = 3'h0,
    FRW_CMD_PROGRAM    = 3'h1,
    FRW_CMD_BLK_ERASE  = 3'h2,
    FRW_CMD_LOCK_PROG  = 3'h3,
    FRW_CMD_PROT_PROG  = 3'h4
  } frw_cmd_e;

  // Sequencer states, one-hot
  typedef enum logic [2:0]
  {
    FRW_ST_READ_ARRAY = 3'b001,
    FRW_ST_BUSY       = 3'b010,
    FRW_ST_DONE       = 3'b100
  } frw_state_e;

  // The four high-priority abort sources
  typedef struct packed
  {
    logic nmi;
    logic watchdog;
    logic osc_stop;
    logic low_voltage;
  } frw_irq_s;

  // Command request from the CPU side
  typedef struct packed
  {
    frw_cmd_e          cmd;
    logic [WEAR_WIDTH-1:0] block;
  } frw_req_s;

endpackage : frw_pkg

// ==== design/frw_wear_mem.sv ====
// Per-block program/erase cycle counter memory with registered read
`timescale 1ns/1ps
module frw_wear_mem #(
  parameter int BLOCKS = 16,
  parameter int AW     = 4,
  parameter int DW     = 16
) (
  input  wire logic          ref_clk,  // System clock
  input  wire logic [AW-1:0] rd_addr,  // Read block index
  output logic      [DW-1:0] rd_data,  // Registered read data
  input  wire logic          wr_en,    // Write strobe
  input  wire logic [AW-1:0] wr_addr,  // Write block index
  input  wire logic [DW-1:0] wr_data   // Write data
);

  logic [DW-1:0] mem [BLOCKS];

  // Counters start at zero in a fresh part; no reset keeps it RAM-like
  initial
  begin
    for (int i = 0; i < BLOCKS; i++)
      mem[i] = '0;
  end

  // Write port
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end

  // Registered read port
  always_ff @(posedge ref_clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule : frw_wear_mem

// ==== design/frw_sequencer.sv ====
// Flash rewrite sequencer with high-priority interrupt abort
//
// How it works
// - Any of four interrupts forces array read mode
// - Those interrupts abort running program or erase
// - Abort resets control A and status registers
// - High-priority interrupts stay serviceable during rewrite
// - Command time grows with block wear count
`timescale 1ns/1ps
module frw_sequencer #(
  parameter int BLOCKS      = 16,
  parameter int BLK_AW      = 4,
  parameter int BASE_CYCLES = frw_pkg::BASE_CMD_CYCLES,
  parameter int WEAR_STEP   = frw_pkg::WEAR_STEP_CYCLES
) (
  input  wire logic                              ref_clk,        // 125 MHz system clock
  input  wire logic                              reset,          // Synchronous, active high
  input  wire frw_pkg::frw_irq_s                 irq_in,         // High-priority interrupt requests
  input  wire logic                              cmd_valid,      // Command issue strobe
  input  wire frw_pkg::frw_cmd_e                 cmd_code,       // Command to run
  input  wire logic [BLK_AW-1:0]                 cmd_block,      // Target block
  input  wire logic                              cpu_rewrite_wr, // Write strobe for CPU rewrite enable
  input  wire logic                              cpu_rewrite_in, // CPU rewrite enable value
  input  wire logic                              mode_sel_wr,    // Write strobe for rewrite_mode_select
  input  wire logic                              mode_sel_in,    // rewrite_mode_select value
  input  wire logic                              lock_dis_wr,    // Write strobe for lock_protect_disable
  input  wire logic                              lock_dis_in,    // lock_protect_disable value
  input  wire logic                              status_clr,     // Clear status flags
  output logic [frw_pkg::CTLA_WIDTH-1:0]         flash_control_register_a, // Control A readback
  output logic [frw_pkg::CTLB_WIDTH-1:0]         flash_control_register_b, // Control B readback
  output logic [frw_pkg::STAT_WIDTH-1:0]         flash_status_register,    // Status readback
  output logic                                   read_array_mode,// Array readable
  output logic                                   busy,           // Command in progress
  output logic                                   irq_pass,       // High-priority interrupt to CPU
  output logic [frw_pkg::WEAR_WIDTH-1:0]         wear_count      // Wear of last commanded block; block 0 after an abort
);

  frw_pkg::frw_state_e              state_r;
  frw_pkg::frw_cmd_e                cmd_r;
  logic [BLK_AW-1:0]                blk_r;
  logic [frw_pkg::CNT_WIDTH-1:0]    cnt_r;
  logic [frw_pkg::CTLA_WIDTH-1:0]   ctla_r;
  logic [frw_pkg::CTLB_WIDTH-1:0]   ctlb_r;
  logic [frw_pkg::STAT_WIDTH-1:0]   stat_r;
  logic [frw_pkg::WEAR_WIDTH-1:0]   wear_rd;
  logic                             load_r;
  logic                             abort;
  logic                             accept;
  logic                             refuse;
  logic                             finish;
  logic                             wear_wr;
  logic                             irq_any;
  logic [frw_pkg::CNT_WIDTH-1:0]    dur;

  // Interrupt requests are from same-clock logic: no synchroniser
  assign irq_any = irq_in.nmi | irq_in.watchdog | irq_in.osc_stop | irq_in.low_voltage;
  assign abort   = irq_any;
  // Interrupts pass through unmasked, even while busy
  assign irq_pass = irq_any;

  // Command accepted only from read mode with CPU rewrite enabled; an abort wins
  assign accept = cmd_valid && !abort && (state_r != frw_pkg::FRW_ST_BUSY)
                  && ctla_r[frw_pkg::CTLA_CPU_REWRITE_BIT] && (cmd_code != frw_pkg::FRW_CMD_NONE)
                  && (cmd_code == frw_pkg::FRW_CMD_PROGRAM || ctlb_r[frw_pkg::CTLB_LOCK_DIS_BIT]
                      || cmd_code != frw_pkg::FRW_CMD_LOCK_PROG);
  assign finish = (state_r == frw_pkg::FRW_ST_BUSY) && !load_r && (cnt_r == '0) && !abort;
  // Locked lock-program attempt: accept never takes it, so flag it here instead
  assign refuse = cmd_valid && !abort && (state_r != frw_pkg::FRW_ST_BUSY)
                  && ctla_r[frw_pkg::CTLA_CPU_REWRITE_BIT] && (cmd_code == frw_pkg::FRW_CMD_LOCK_PROG)
                  && !ctlb_r[frw_pkg::CTLB_LOCK_DIS_BIT];

  // Duration grows with the block's accumulated wear
  function automatic logic [frw_pkg::CNT_WIDTH-1:0] cmd_time(input logic [frw_pkg::WEAR_WIDTH-1:0] w);
    cmd_time = frw_pkg::CNT_WIDTH'(BASE_CYCLES) + frw_pkg::CNT_WIDTH'(w) * frw_pkg::CNT_WIDTH'(WEAR_STEP);
  endfunction : cmd_time

  assign dur = cmd_time(wear_rd);

  // Wear bumps on completion of program or erase only
  assign wear_wr = finish && (cmd_r == frw_pkg::FRW_CMD_PROGRAM || cmd_r == frw_pkg::FRW_CMD_BLK_ERASE);

  frw_wear_mem #(
    .BLOCKS (BLOCKS),
    .AW     (BLK_AW),
    .DW     (frw_pkg::WEAR_WIDTH)
  ) u_wear (
    .ref_clk (ref_clk),
    .rd_addr (accept ? cmd_block : blk_r),
    .rd_data (wear_rd),
    .wr_en   (wear_wr),
    .wr_addr (blk_r),
    .wr_data (wear_rd + frw_pkg::WEAR_WIDTH'(1))
  );

  // Sequencer state; abort always drops back to read array
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_r <= frw_pkg::FRW_ST_READ_ARRAY;
    else if (abort)
      state_r <= frw_pkg::FRW_ST_READ_ARRAY;
    else
    begin
      unique case (state_r)
        frw_pkg::FRW_ST_READ_ARRAY,
        frw_pkg::FRW_ST_DONE:
          if (accept)
            state_r <= frw_pkg::FRW_ST_BUSY;
        frw_pkg::FRW_ST_BUSY:
          if (finish)
            state_r <= frw_pkg::FRW_ST_DONE;
        default:
          state_r <= frw_pkg::FRW_ST_READ_ARRAY;
      endcase
    end
  end

  // Latched command; cleared on abort so nothing resumes by itself
  always_ff @(posedge ref_clk)
  begin
    if (reset || abort)
    begin
      cmd_r <= frw_pkg::FRW_CMD_NONE;
      blk_r <= '0;
    end
    else if (accept)
    begin
      cmd_r <= cmd_code;
      blk_r <= cmd_block;
    end
  end

  // Countdown; one cycle of load lets the wear read settle
  always_ff @(posedge ref_clk)
  begin
    if (reset || abort)
    begin
      load_r <= 1'b0;
      cnt_r  <= '0;
    end
    else if (accept)
      load_r <= 1'b1;
    else if (load_r)
    begin
      load_r <= 1'b0;
      cnt_r  <= dur - frw_pkg::CNT_WIDTH'(1);
    end
    else if (state_r == frw_pkg::FRW_ST_BUSY && cnt_r != '0)
      cnt_r <= cnt_r - frw_pkg::CNT_WIDTH'(1);
  end

  // Control register A: abort returns it to reset value
  always_ff @(posedge ref_clk)
  begin
    if (reset || abort)
      ctla_r <= frw_pkg::CTLA_RESET;
    else
    begin
      if (cpu_rewrite_wr)
        ctla_r[frw_pkg::CTLA_CPU_REWRITE_BIT] <= cpu_rewrite_in;
      if (mode_sel_wr)
        ctla_r[frw_pkg::CTLA_MODE_SEL_BIT] <= mode_sel_in;
      ctla_r[frw_pkg::CTLA_RDY_BIT] <= !(accept || (state_r == frw_pkg::FRW_ST_BUSY && !finish));
    end
  end

  // Control register B: abort clears lock disable; lock disable also auto-clears per command
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ctlb_r <= frw_pkg::CTLB_RESET;
    else if (abort)
      ctlb_r[frw_pkg::CTLB_LOCK_DIS_BIT] <= 1'b0;
    else if (lock_dis_wr)
      ctlb_r[frw_pkg::CTLB_LOCK_DIS_BIT] <= lock_dis_in;
    else if (finish)
      ctlb_r[frw_pkg::CTLB_LOCK_DIS_BIT] <= 1'b0;
  end

  // Status register: abort resets it; set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (reset || abort)
      stat_r <= frw_pkg::STAT_RESET;
    else if (refuse)
      stat_r[frw_pkg::STAT_PROG_ERR_BIT] <= 1'b1;
    else if (status_clr)
      stat_r <= frw_pkg::STAT_RESET;
  end

  // Outputs
  assign flash_control_register_a = ctla_r;
  assign flash_control_register_b = ctlb_r;
  assign flash_status_register    = stat_r;
  assign busy                     = (state_r == frw_pkg::FRW_ST_BUSY);
  assign read_array_mode          = (state_r != frw_pkg::FRW_ST_BUSY);
  assign wear_count               = wear_rd;

endmodule : frw_sequencer

// ==== tb/frw_sequencer_asserts.sv ====
// Port-level assertions for the rewrite sequencer
`timescale 1ns/1ps
module frw_sequencer_asserts (
  input wire logic              ref_clk,                  // Clock
  input wire logic              reset,                    // Sync reset
  input wire frw_pkg::frw_irq_s irq_in,                   // Abort sources
  input wire logic              cmd_valid,                // Issue strobe
  input wire frw_pkg::frw_cmd_e cmd_code,                 // Command
  input wire logic [7:0]        flash_control_register_a, // Control A
  input wire logic [7:0]        flash_control_register_b, // Control B
  input wire logic [7:0]        flash_status_register,    // Status
  input wire logic              read_array_mode,          // Array mode
  input wire logic              busy,                     // Busy
  input wire logic              irq_pass                  // To CPU
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Command takes only when idle, enabled and no abort pending
  wire logic any_irq = |irq_in;
  wire logic go      = cmd_valid && !busy && !any_irq && flash_control_register_a[2];
  abort_idle_a: assert property (any_irq |=> !busy && read_array_mode)
    else $error("abort left sequencer busy");
  abort_regs_a: assert property (any_irq |=> flash_control_register_a == frw_pkg::CTLA_RESET
    && flash_status_register == frw_pkg::STAT_RESET) else $error("abort kept register values");
  irq_pass_a: assert property (irq_pass == any_irq) else $error("interrupt not passed");
  no_resume_a: assert property (!busy && !cmd_valid |=> !busy) else $error("busy without command");
  mode_view_a: assert property (read_array_mode == !busy && flash_control_register_a[0] == !busy)
    else $error("mode or ready disagree with busy");
  done_bound_a: assert property ($rose(busy) |-> ##[1:600] !busy) else $error("command never ended");
  accept_a: assert property (go && cmd_code inside {frw_pkg::FRW_CMD_PROGRAM, frw_pkg::FRW_CMD_BLK_ERASE}
    |=> busy) else $error("command not taken");
  lock_refuse_a: assert property (go && cmd_code == frw_pkg::FRW_CMD_LOCK_PROG && !flash_control_register_b[0]
    |=> !busy && flash_status_register[0]) else $error("locked program not refused");
  abort_lock_a: assert property (any_irq |=> !flash_control_register_b[0]) else $error("lock disable kept");
  c_abort_busy: cover property (busy && any_irq);
  c_done: cover property ($fell(busy) && !$past(any_irq));
  c_refuse: cover property (go && cmd_code == frw_pkg::FRW_CMD_LOCK_PROG && !flash_control_register_b[0]);
endmodule : frw_sequencer_asserts

bind frw_sequencer frw_sequencer_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .irq_in(irq_in),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .flash_control_register_a(flash_control_register_a),
  .flash_control_register_b(flash_control_register_b), .flash_status_register(flash_status_register),
  .read_array_mode(read_array_mode), .busy(busy), .irq_pass(irq_pass));

// ==== tb/frw_cpu_model.sv ====
// CPU rewrite program model: re-arms mode and lock after handlers
`timescale 1ns/1ps
module frw_cpu_model (
  input  wire logic ref_clk,            // System clock
  input  wire logic irq_pass,           // Interrupt seen by CPU
  input  wire logic setup,              // Bench asks to arm
  input  wire logic flash_mode,         // Selects flash-resident mode
  output logic      mode_sel_wr = 1'b0, // Mode strobe
  output logic      mode_sel_in,        // Mode value
  output logic      lock_dis_wr = 1'b0, // Lock disable strobe
  output logic      lock_dis_in         // Lock disable value
);
  logic irq_prev_r = 1'b0;
  logic pend_r     = 1'b0;
  // Handler end is the fall of the interrupt; only fixed-vector sources, no traps
  always @(posedge ref_clk)
  begin
    irq_prev_r <= irq_pass;
    pend_r     <= setup || (irq_prev_r && !irq_pass);
  end
  // Strobes move off the sampling edge so the write is clean
  always @(negedge ref_clk)
  begin
    mode_sel_wr <= pend_r;
    lock_dis_wr <= pend_r;
  end
  assign mode_sel_in = flash_mode;
  assign lock_dis_in = 1'b1;
endmodule : frw_cpu_model

// ==== tb/tb_flash_rewrite_interrupt_abort.sv ====
// Self-checking bench for sequencer interrupt abort
`timescale 1ns/1ps
module tb_flash_rewrite_interrupt_abort;
  logic              ref_clk   = 1'b0;
  logic              reset     = 1'b1;
  frw_pkg::frw_irq_s irq_in    = '0;
  logic              cmd_valid = 1'b0;
  frw_pkg::frw_cmd_e cmd_code  = frw_pkg::FRW_CMD_NONE;
  logic [3:0]        cmd_block = 4'h0;
  logic              cpu_wr    = 1'b0;
  logic              clr       = 1'b0;
  logic              setup     = 1'b0;
  logic              fmode     = 1'b0;
  logic              ms_wr, ms_in, ld_wr, ld_in, rd_mode, busy, irq_pass;
  logic [7:0]        ctla, ctlb, stat;
  logic [15:0]       wear;
  int                errors    = 0;
  int                n_checks  = 0;
  int                cyc       = 0;
  // Short base time keeps the run brief
  frw_sequencer #(.BASE_CYCLES(10), .WEAR_STEP(8)) u_dut (.ref_clk(ref_clk), .reset(reset), .irq_in(irq_in),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_block(cmd_block), .cpu_rewrite_wr(cpu_wr),
    .cpu_rewrite_in(1'b1), .mode_sel_wr(ms_wr), .mode_sel_in(ms_in), .lock_dis_wr(ld_wr), .lock_dis_in(ld_in),
    .status_clr(clr), .flash_control_register_a(ctla), .flash_control_register_b(ctlb),
    .flash_status_register(stat), .read_array_mode(rd_mode), .busy(busy), .irq_pass(irq_pass), .wear_count(wear));
  frw_cpu_model u_cpu (.ref_clk(ref_clk), .irq_pass(irq_pass), .setup(setup), .flash_mode(fmode),
    .mode_sel_wr(ms_wr), .mode_sel_in(ms_in), .lock_dis_wr(ld_wr), .lock_dis_in(ld_in));
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : ticks
  task automatic issue(input frw_pkg::frw_cmd_e c, input logic [3:0] b);
    cpu_wr = 1'b1;
    ticks(1);
    cpu_wr = 1'b0;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_block = b;
    ticks(1);
    cmd_valid = 1'b0;
  endtask : issue
  task automatic do_cmd(input frw_pkg::frw_cmd_e c, input logic [3:0] b, output int n);
    issue(c, b);
    chk("busy", busy, 1'b1);
    n = 0;
    while (busy === 1'b1 && n < 2000)
    begin
      ticks(1);
      n++;
    end
    chk("ready", ctla[0], 1'b1);
  endtask : do_cmd
  task automatic arm(input logic fm);
    fmode = fm;
    setup = 1'b1;
    ticks(1);
    setup = 1'b0;
    ticks(4);
  endtask : arm
  // Refused lock program, clear, then every command code except NONE runs
  task automatic t_cmds();
    int n0;
    int n1;
    chk("ctla rst", ctla, frw_pkg::CTLA_RESET);
    chk("stat rst", stat, frw_pkg::STAT_RESET);
    issue(frw_pkg::FRW_CMD_LOCK_PROG, 4'h1);
    chk("refused", {busy, stat[0]}, 8'h01);
    clr = 1'b1;
    ticks(1);
    clr = 1'b0;
    chk("cleared", stat, 8'h00);
    arm(1'b0);
    do_cmd(frw_pkg::FRW_CMD_LOCK_PROG, 4'h1, n0);
    do_cmd(frw_pkg::FRW_CMD_BLK_ERASE, 4'h7, n0);
    do_cmd(frw_pkg::FRW_CMD_PROT_PROG, 4'h7, n0);
    do_cmd(frw_pkg::FRW_CMD_PROGRAM, 4'h5, n0);
    do_cmd(frw_pkg::FRW_CMD_PROGRAM, 4'h5, n1);
    chk("wear step", 8'(n1 - n0), 8'h08);
    ticks(1);
    chk("wear cnt", wear[7:0], 8'h02);
  endtask : t_cmds
  // Abort mid-program from source i; watchdog only in RAM mode
  task automatic t_abort(input int i);
    int n;
    issue(frw_pkg::FRW_CMD_LOCK_PROG, 4'h2);
    arm(i[0]);
    issue(frw_pkg::FRW_CMD_PROGRAM, 4'h4);
    ticks(3);
    irq_in = frw_pkg::frw_irq_s'(4'h1 << i);
    ticks(1);
    chk("irq pass", irq_pass, 1'b1);
    chk("aborted", {busy, rd_mode}, 8'h01);
    chk("ctla abort", ctla, frw_pkg::CTLA_RESET);
    chk("stat abort", stat, frw_pkg::STAT_RESET);
    irq_in = '0;
    ticks(30);
    chk("no resume", busy, 1'b0);
    chk("restored", {ctlb[0], ctla[1]}, {6'h00, 1'b1, i[0]});
    do_cmd(frw_pkg::FRW_CMD_PROGRAM, 4'h4, n);
  endtask : t_abort
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    ticks(20);
    reset = 1'b0;
    ticks(1);
    t_cmds();
    for (int i = 0; i < 4; i++)
      t_abort(i);
    give_verdict();
  end
endmodule : tb_flash_rewrite_interrupt_abort
